// ===== core/dcel_pkg.sv
// ==========================================================================
// Shared constants and types for the dual comparator event logic.
// ==========================================================================
package dcel_pkg;

	// ======================================================================
	// Register map.
	// ======================================================================
	localparam logic [7:0] ADDR_ACSR_A = 8'h97;
	localparam logic [7:0] ADDR_ACSR_B = 8'h9f;
	localparam logic [7:0] ADDR_REF_CTRL = 8'h9e;
	localparam logic [7:0] RESET_ACSR = 8'h00;
	localparam logic [7:0] RESET_REF_CTRL = 8'h00;

	// Control/status field positions (same layout for both comparators).
	localparam int ACSR_CHAN_LSB = 6;
	localparam int ACSR_CONNECT_BIT = 5;
	localparam int ACSR_FLAG_BIT = 4;
	localparam int ACSR_ENABLE_BIT = 3;
	localparam int ACSR_COND_LSB = 0;

	// Reference control field positions.
	localparam int REF_A_SEL_LSB = 0;
	localparam int REF_B_SEL_LSB = 2;
	localparam int REF_A_SRC_LSB = 4;
	localparam int REF_B_SRC_LSB = 6;

	// ======================================================================
	// Encodings.
	// ======================================================================
	localparam logic [2:0] COND_LOW = 3'h0;
	localparam logic [2:0] COND_HIGH = 3'h1;
	localparam logic [2:0] COND_TOGGLE = 3'h2;
	localparam logic [2:0] COND_FALL = 3'h4;
	localparam logic [2:0] COND_RISE = 3'h5;

	localparam logic [1:0] SRC_CLOCK = 2'h0;
	localparam logic [1:0] SRC_TIMER0 = 2'h1;
	localparam logic [1:0] SRC_TIMER1 = 2'h2;
	localparam logic [1:0] SRC_TIMER2 = 2'h3;

	localparam logic [1:0] REF_NOMINAL = 2'h0;
	localparam logic [1:0] REF_ABOVE = 2'h1;
	localparam logic [1:0] REF_BELOW = 2'h2;

	// ======================================================================
	// Counts and times.
	// ======================================================================
	localparam int DEBOUNCE_OVERFLOWS = 2;
	localparam int STABLE_SAMPLES = 4;
	localparam int CLK_PERIOD_NS = 40;
	localparam int SETTLE_TIME_NS = 10000;
	localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ======================================================================
	// Types.
	// ======================================================================
	typedef enum logic {
		DEB_IDLE,
		DEB_WAIT
	} dcel_deb_state_t;

	typedef struct packed {
		logic [1:0] chan;
		logic connect;
		logic enable;
		logic [2:0] cond;
		logic [1:0] ref_sel;
		logic [1:0] src;
	} dcel_cfg_t;

endpackage : dcel_pkg

// ===== core/dcel_cmp_front.sv
`timescale 1ns/1ps
// ==========================================================================
// Qualifies one analog comparator result.
// ==========================================================================
module dcel_cmp_front (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic enable,
	input wire logic power_down,
	input wire logic raw_gt,
	output logic active,
	output logic result
);
	logic active_ff;
	logic result_ff;
	logic nxt_active;
	logic nxt_result;

	// Power-down overrides the enable bit; a disabled comparator reads low.
	always_comb begin
		nxt_active = enable & ~power_down; // R01 R09
		nxt_result = nxt_active & raw_gt; // R18 R20
	end

	// Registering the result keeps the event logic free of analog glitches.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active_ff <= 1'b0;
			result_ff <= 1'b0;
		end else if (ce) begin
			active_ff <= nxt_active;
			result_ff <= nxt_result;
		end
	end

	assign active = active_ff;
	assign result = result_ff;

	a_off_reads_low: assert property (@(posedge clk) disable iff (!rst_n) (ce && (!enable || power_down)) |=> (!result && !active)) // R20
		else $error("Disabled comparator did not read low.");
endmodule : dcel_cmp_front

// ===== core/dcel_event_unit.sv
`timescale 1ns/1ps
// ==========================================================================
// Event detection for one comparator: levels, edges, debounce.
// ==========================================================================
module dcel_event_unit #(
	parameter int STABLE_N = dcel_pkg::STABLE_SAMPLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic active,
	input wire logic result,
	input wire logic [2:0] cond,
	input wire logic [1:0] src,
	input wire logic t0_ovf,
	input wire logic t1_ovf,
	input wire logic t2_ovf,
	output logic event_pulse
);
	dcel_pkg::dcel_deb_state_t state_ff, nxt_state;
	logic smp_ff, nxt_smp;
	logic [STABLE_N-1:0] hist_ff, nxt_hist;
	logic stab_ff, nxt_stab;
	logic [1:0] ovf_cnt_ff, nxt_ovf_cnt;
	logic exp_ff, nxt_exp;
	logic evt_ff, nxt_evt;
	logic tick;
	logic is_edge;
	logic rise;
	logic fall;
	logic relevant;

	// Sample strobe and edge classification.
	always_comb begin
		case (src) // R07
			dcel_pkg::SRC_CLOCK: tick = 1'b1;
			dcel_pkg::SRC_TIMER0: tick = t0_ovf;
			dcel_pkg::SRC_TIMER1: tick = t1_ovf;
			dcel_pkg::SRC_TIMER2: tick = t2_ovf;
			default: tick = 1'b1;
		endcase
		is_edge = (cond == dcel_pkg::COND_RISE) || (cond == dcel_pkg::COND_FALL) ||
			(cond == dcel_pkg::COND_TOGGLE);
		rise = result & ~smp_ff;
		fall = ~result & smp_ff;
		relevant = ((cond == dcel_pkg::COND_RISE) & rise) | ((cond == dcel_pkg::COND_FALL) & fall) |
			((cond == dcel_pkg::COND_TOGGLE) & (rise | fall));
	end

	// Next-state logic. Disabled units drop any pending event.
	always_comb begin
		nxt_state = state_ff;
		nxt_smp = smp_ff;
		nxt_hist = hist_ff;
		nxt_stab = stab_ff;
		nxt_ovf_cnt = ovf_cnt_ff;
		nxt_exp = exp_ff;
		nxt_evt = 1'b0;
		if (!active) begin
			nxt_state = dcel_pkg::DEB_IDLE; // R20
			nxt_smp = 1'b0;
			nxt_hist = '0;
			nxt_stab = 1'b0;
			nxt_ovf_cnt = 2'h0;
		end else if (!is_edge) begin
			nxt_smp = result;
			if (tick && (cond == dcel_pkg::COND_HIGH) && result) nxt_evt = 1'b1; // R04
			if (tick && (cond == dcel_pkg::COND_LOW) && !result) nxt_evt = 1'b1; // R04
		end else if (src == dcel_pkg::SRC_CLOCK) begin
			nxt_smp = result;
			case (state_ff)
				dcel_pkg::DEB_IDLE: begin
					if (relevant) begin // R14
						nxt_state = dcel_pkg::DEB_WAIT;
						nxt_exp = result;
						nxt_ovf_cnt = 2'h0;
					end
				end
				dcel_pkg::DEB_WAIT: begin
					if (t1_ovf) begin
						nxt_ovf_cnt = ovf_cnt_ff + 2'h1;
						if (ovf_cnt_ff == 2'(dcel_pkg::DEBOUNCE_OVERFLOWS - 1)) begin // R14
							nxt_state = dcel_pkg::DEB_IDLE;
							nxt_evt = (result == exp_ff); // R15
						end
					end
				end
				default: nxt_state = dcel_pkg::DEB_IDLE;
			endcase
		end else if (tick) begin
			// Timer pacing: a change counts only after STABLE_N equal samples.
			nxt_hist = {hist_ff[STABLE_N-2:0], result};
			if (((&nxt_hist) || !(|nxt_hist)) && (result != stab_ff)) begin // R16
				nxt_stab = result;
				nxt_evt = (cond == dcel_pkg::COND_TOGGLE) || ((cond == dcel_pkg::COND_RISE) == result); // R04
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= dcel_pkg::DEB_IDLE;
			smp_ff <= 1'b0;
			hist_ff <= '0;
			stab_ff <= 1'b0;
			ovf_cnt_ff <= 2'h0;
			exp_ff <= 1'b0;
			evt_ff <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state;
			smp_ff <= nxt_smp;
			hist_ff <= nxt_hist;
			stab_ff <= nxt_stab;
			ovf_cnt_ff <= nxt_ovf_cnt;
			exp_ff <= nxt_exp;
			evt_ff <= nxt_evt;
		end
	end

	assign event_pulse = evt_ff;

	a_idle_no_event: assert property (@(posedge clk) disable iff (!rst_n) (ce && !active) |=> !event_pulse) // R20
		else $error("Event reported while comparator disabled.");
	a_level_high_evt: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && active && tick && cond == dcel_pkg::COND_HIGH && result) |=> event_pulse) // R04
		else $error("High level missed.");
	a_debounce_delay: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && active && src == dcel_pkg::SRC_CLOCK && is_edge && state_ff == dcel_pkg::DEB_IDLE && relevant)
		|=> (!event_pulse && state_ff == dcel_pkg::DEB_WAIT)) // R14
		else $error("Debounce did not wait for timer overflows.");
	a_stable_count: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && active && src != dcel_pkg::SRC_CLOCK && is_edge && tick && !(&hist_ff[STABLE_N-2:0])
		&& result) |=> !event_pulse) // R16
		else $error("Edge accepted before enough stable samples.");
endmodule : dcel_event_unit

// ===== core/dcel_top.sv
// Our own choice: strobed register access.
`timescale 1ns/1ps
// Function
// R01: Each comparator runs only while its enable bit is set.
// R02: Inputs are attached only while the connect bit is set.
// R03: Software keeps interrupt off during settling and clears flag first.
// R04: Flag sets on high, low, rising, falling or toggle per condition field.
// R05: Flags stay set until software clears them.
// R06: Both flags drive one shared interrupt request.
// R07: Sample source selects every clock or timer 0, 1, 2 overflow.
// R08: Comparators keep running in idle.
// R09: Power-down forces both comparators disabled.
// R10: Channel field routes one of four analog pins to positive input.
// R11: Software clears connect before changing channel or reference selection.
// R12: Software keeps interrupt off and clears flag while reselecting inputs.
// R13: Reference field picks nominal, above or below internal level.
// R14: Debounce mode waits two timer 1 overflows before resampling.
// R15: Debounce resample sets flag only when the sample matches expectation.
// R16: Timer-paced edges need four consecutive equal samples.
// R17: Control/status register resets to zero with the given field layout.
// R18: Result is one when positive input exceeds negative input.
// R19: Channel codes 0 to 3 select analog inputs 0 to 3.
// R20: Disabled comparator output forced low, no further events.
// R21: Comparator B has an identical control/status register.
module dcel_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic t0_ovf,
	input wire logic t1_ovf,
	input wire logic t2_ovf,
	input wire logic idle,
	input wire logic power_down,
	input wire logic cmp_a_raw_gt,
	input wire logic cmp_b_raw_gt,
	output logic cmp_a_powered,
	output logic cmp_b_powered,
	output logic cmp_a_connect,
	output logic cmp_b_connect,
	output logic [1:0] cmp_a_channel_sel,
	output logic [1:0] cmp_b_channel_sel,
	output logic [1:0] cmp_a_ref_sel,
	output logic [1:0] cmp_b_ref_sel,
	output logic cmp_irq
);
	// ======================================================================
	// Register state.
	// ======================================================================
	logic [7:0] acsr_a_ff, nxt_acsr_a;
	logic [7:0] acsr_b_ff, nxt_acsr_b;
	logic [7:0] ref_ctrl_ff, nxt_ref_ctrl;
	logic [7:0] rdata_ff, nxt_rdata;
	logic irq_ff, nxt_irq;
	dcel_pkg::dcel_cfg_t cfg [2];
	logic [1:0] active;
	logic [1:0] result;
	logic [1:0] evt;
	logic [1:0] raw_gt;
	logic wr_a;
	logic wr_b;
	logic wr_ref;
	logic idle_unused;

	// Idle has no effect: the comparators keep running by design.
	assign idle_unused = idle; // R08

	assign raw_gt = {cmp_b_raw_gt, cmp_a_raw_gt};

	// ======================================================================
	// Configuration unpacking.
	// ======================================================================
	// Both comparators share one field layout; B mirrors A.
	always_comb begin
		cfg[0].chan = acsr_a_ff[dcel_pkg::ACSR_CHAN_LSB +: 2];
		cfg[0].connect = acsr_a_ff[dcel_pkg::ACSR_CONNECT_BIT];
		cfg[0].enable = acsr_a_ff[dcel_pkg::ACSR_ENABLE_BIT];
		cfg[0].cond = acsr_a_ff[dcel_pkg::ACSR_COND_LSB +: 3];
		cfg[0].ref_sel = ref_ctrl_ff[dcel_pkg::REF_A_SEL_LSB +: 2];
		cfg[0].src = ref_ctrl_ff[dcel_pkg::REF_A_SRC_LSB +: 2];
		cfg[1].chan = acsr_b_ff[dcel_pkg::ACSR_CHAN_LSB +: 2]; // R21
		cfg[1].connect = acsr_b_ff[dcel_pkg::ACSR_CONNECT_BIT];
		cfg[1].enable = acsr_b_ff[dcel_pkg::ACSR_ENABLE_BIT];
		cfg[1].cond = acsr_b_ff[dcel_pkg::ACSR_COND_LSB +: 3];
		cfg[1].ref_sel = ref_ctrl_ff[dcel_pkg::REF_B_SEL_LSB +: 2];
		cfg[1].src = ref_ctrl_ff[dcel_pkg::REF_B_SRC_LSB +: 2];
	end

	// ======================================================================
	// Per-comparator qualification and event detection.
	// ======================================================================
	for (genvar i = 0; i < 2; i++) begin : g_cmp
		dcel_cmp_front u_front (
			.clk(clk),
			.rst_n(rst_n),
			.ce(ce),
			.enable(cfg[i].enable),
			.power_down(power_down),
			.raw_gt(raw_gt[i]),
			.active(active[i]),
			.result(result[i])
		);
		dcel_event_unit #(
			.STABLE_N(dcel_pkg::STABLE_SAMPLES)
		) u_evt (
			.clk(clk),
			.rst_n(rst_n),
			.ce(ce),
			.active(active[i]),
			.result(result[i]),
			.cond(cfg[i].cond),
			.src(cfg[i].src),
			.t0_ovf(t0_ovf),
			.t1_ovf(t1_ovf),
			.t2_ovf(t2_ovf),
			.event_pulse(evt[i])
		);
	end

	// ======================================================================
	// Register bus.
	// ======================================================================
	assign wr_a = wr && (addr == dcel_pkg::ADDR_ACSR_A);
	assign wr_b = wr && (addr == dcel_pkg::ADDR_ACSR_B);
	assign wr_ref = wr && (addr == dcel_pkg::ADDR_REF_CTRL);

	// Writes load all fields except the flag, which software may only clear by
	// writing zero. A hardware event in the same cycle wins over the clear, so
	// an edge arriving in the write cycle of a read-modify-write is never lost.
	always_comb begin
		nxt_acsr_a = acsr_a_ff;
		nxt_acsr_b = acsr_b_ff;
		nxt_ref_ctrl = ref_ctrl_ff;
		if (wr_a) begin
			nxt_acsr_a = wdata;
			nxt_acsr_a[dcel_pkg::ACSR_FLAG_BIT] = acsr_a_ff[dcel_pkg::ACSR_FLAG_BIT] &
				wdata[dcel_pkg::ACSR_FLAG_BIT]; // R05
		end
		if (wr_b) begin
			nxt_acsr_b = wdata; // R21
			nxt_acsr_b[dcel_pkg::ACSR_FLAG_BIT] = acsr_b_ff[dcel_pkg::ACSR_FLAG_BIT] &
				wdata[dcel_pkg::ACSR_FLAG_BIT]; // R05
		end
		if (wr_ref) begin
			nxt_ref_ctrl = wdata;
		end
		if (evt[0]) begin
			nxt_acsr_a[dcel_pkg::ACSR_FLAG_BIT] = 1'b1; // R04
		end
		if (evt[1]) begin
			nxt_acsr_b[dcel_pkg::ACSR_FLAG_BIT] = 1'b1; // R04
		end
	end

	// Read data stand for exactly the cycle after the strobe; unmapped reads
	// return zero.
	always_comb begin
		nxt_rdata = 8'h00;
		if (rd) begin
			case (addr)
				dcel_pkg::ADDR_ACSR_A: nxt_rdata = acsr_a_ff;
				dcel_pkg::ADDR_ACSR_B: nxt_rdata = acsr_b_ff;
				dcel_pkg::ADDR_REF_CTRL: nxt_rdata = ref_ctrl_ff;
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	// One request line for both comparators; the handler reads flags to tell
	// which one fired.
	always_comb begin
		nxt_irq = nxt_acsr_a[dcel_pkg::ACSR_FLAG_BIT] | nxt_acsr_b[dcel_pkg::ACSR_FLAG_BIT]; // R06
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acsr_a_ff <= dcel_pkg::RESET_ACSR; // R17
			acsr_b_ff <= dcel_pkg::RESET_ACSR;
			ref_ctrl_ff <= dcel_pkg::RESET_REF_CTRL;
			rdata_ff <= 8'h00;
			irq_ff <= 1'b0;
		end else if (ce) begin
			acsr_a_ff <= nxt_acsr_a;
			acsr_b_ff <= nxt_acsr_b;
			ref_ctrl_ff <= nxt_ref_ctrl;
			rdata_ff <= nxt_rdata;
			irq_ff <= nxt_irq;
		end
	end

	// ======================================================================
	// Analog controls.
	// ======================================================================
	// Selects come straight from register flops so the mux settings are
	// glitch free; software sequences connect around any change.
	assign cmp_a_connect = cfg[0].connect; // R02
	assign cmp_b_connect = cfg[1].connect; // R02
	assign cmp_a_channel_sel = cfg[0].chan; // R10 R19
	assign cmp_b_channel_sel = cfg[1].chan; // R10
	assign cmp_a_ref_sel = cfg[0].ref_sel; // R13
	assign cmp_b_ref_sel = cfg[1].ref_sel; // R13
	assign cmp_a_powered = active[0]; // R01 R09
	assign cmp_b_powered = active[1]; // R01 R09
	assign rdata = rdata_ff;
	assign cmp_irq = irq_ff;

	// ======================================================================
	// Checks.
	// ======================================================================
	a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n) // R05
		(ce && acsr_a_ff[dcel_pkg::ACSR_FLAG_BIT] && !(wr_a && !wdata[dcel_pkg::ACSR_FLAG_BIT]))
		|=> acsr_a_ff[dcel_pkg::ACSR_FLAG_BIT])
		else $error("Flag A cleared without software.");
	a_flag_set_wins: assert property (@(posedge clk) disable iff (!rst_n) // R04
		(ce && evt[1]) |=> acsr_b_ff[dcel_pkg::ACSR_FLAG_BIT])
		else $error("Event on B did not set its flag.");
	a_irq_shared: assert property (@(posedge clk) disable iff (!rst_n) // R06
		(ce && (evt[0] || evt[1])) |=> cmp_irq)
		else $error("Shared request not raised.");
	a_read_acsr: assert property (@(posedge clk) disable iff (!rst_n) // R17
		(ce && rd && addr == dcel_pkg::ADDR_ACSR_A) |=> (rdata == $past(acsr_a_ff)))
		else $error("Read data mismatch.");
	a_pd_disable: assert property (@(posedge clk) disable iff (!rst_n) // R09
		(ce && power_down) |=> (!cmp_a_powered && !cmp_b_powered))
		else $error("Comparator powered in power-down.");
	a_enable_follows: assert property (@(posedge clk) disable iff (!rst_n) // R01
		(ce && !power_down && cfg[0].enable) ##1 (ce && !power_down && cfg[0].enable) |=> cmp_a_powered)
		else $error("Enabled comparator A not active.");
	a_write_ctrl: assert property (@(posedge clk) disable iff (!rst_n) // R21
		(ce && wr_b) |=> (acsr_b_ff[7:5] == $past(wdata[7:5]) && acsr_b_ff[3:0] == $past(wdata[3:0])))
		else $error("Register B write lost.");
endmodule : dcel_top

// ===== tb/dcel_far_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Far side: four shared analog levels, the reference ladder and three timers.
// ==========================================================================
module dcel_far_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tmr_run,
	input wire logic [3:0][7:0] ain,
	input wire logic [1:0] on,
	input wire logic [1:0] con,
	input wire logic [1:0] ch_a,
	input wire logic [1:0] ch_b,
	input wire logic [1:0] rf_a,
	input wire logic [1:0] rf_b,
	output logic gt_a,
	output logic gt_b,
	output logic t0,
	output logic t1,
	output logic t2
);
	logic [7:0] cnt;

	// Reference ladder in arbitrary units: nominal, one step above, one step below.
	function automatic logic [7:0] ref_lvl(input logic [1:0] s);
		case (s)
			2'h1: ref_lvl = 8'h89;
			2'h2: ref_lvl = 8'h71;
			default: ref_lvl = 8'h7d;
		endcase
	endfunction : ref_lvl

	// Cores are registered so they look like synchronous levels to the block.
	// An unpowered or disconnected core reads low, so stale levels never leak through.
	// Timer periods are coprime so that no two overflows keep lining up.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gt_a <= 1'b0;
			gt_b <= 1'b0;
			cnt <= 8'h00;
			t0 <= 1'b0;
			t1 <= 1'b0;
			t2 <= 1'b0;
		end else begin
			gt_a <= on[0] && con[0] && (ain[ch_a] > ref_lvl(rf_a));
			gt_b <= on[1] && con[1] && (ain[ch_b] > ref_lvl(rf_b));
			cnt <= tmr_run ? cnt + 8'h01 : cnt;
			t0 <= tmr_run && (cnt % 5 == 4);
			t1 <= tmr_run && (cnt % 7 == 6);
			t2 <= tmr_run && (cnt % 11 == 10);
		end
	end
endmodule : dcel_far_model

// ===== tb/dcel_top_bench.sv
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench: register accesses, conditions, sampling and power states.
// ==========================================================================
module dcel_top_bench;
	localparam logic [7:0] RA = dcel_pkg::ADDR_ACSR_A;
	localparam logic [7:0] RB = dcel_pkg::ADDR_ACSR_B;
	localparam logic [7:0] RF = dcel_pkg::ADDR_REF_CTRL;
	localparam logic [7:0] HI = 8'ha0;
	localparam logic [7:0] LO = 8'h40;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic idle = 1'b0;
	logic power_down = 1'b0;
	logic tmr_run = 1'b0;
	logic ce = 1'b1;
	logic [3:0][7:0] ain = '0;
	logic [7:0] rdata;
	logic t0, t1, t2, gt_a, gt_b, pw_a, pw_b, con_a, con_b, irq;
	logic [1:0] ch_a, ch_b, rf_a, rf_b;
	logic [2:0] cnd [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h5, 3'h3};
	logic [6:0] st = 7'b0101001;
	logic [6:0] ex = 7'b0011111;
	int n_errors = 0;
	int n_compared = 0;

	// Free-running 25 MHz clock.
	always #20 clk = ~clk;

	dcel_top dcel_top_i (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .t0_ovf(t0), .t1_ovf(t1), .t2_ovf(t2), .idle(idle), .power_down(power_down),
		.cmp_a_raw_gt(gt_a), .cmp_b_raw_gt(gt_b), .cmp_a_powered(pw_a), .cmp_b_powered(pw_b),
		.cmp_a_connect(con_a), .cmp_b_connect(con_b), .cmp_a_channel_sel(ch_a), .cmp_b_channel_sel(ch_b),
		.cmp_a_ref_sel(rf_a), .cmp_b_ref_sel(rf_b), .cmp_irq(irq));

	dcel_far_model dcel_far_model_i (.clk(clk), .rst_n(rst_n), .tmr_run(tmr_run), .ain(ain),
		.on({pw_b, pw_a}), .con({con_b, con_a}), .ch_a(ch_a), .ch_b(ch_b), .rf_a(rf_a), .rf_b(rf_b),
		.gt_a(gt_a), .gt_b(gt_b), .t0(t0), .t1(t1), .t2(t2));

	// ======================================================================
	// Access and comparison tasks.
	// ======================================================================
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask : expect_reg

	task automatic lvl(input int i, input logic [7:0] v);
		@(posedge clk);
		ain[i] <= v;
	endtask : lvl

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	// Bounded wait; a hang is counted and ends the run at once.
	task automatic wait_irq;
		int k;
		k = 0;
		while (irq !== 1'b1 && k < 200) begin
			step(1);
			k++;
		end
		if (irq !== 1'b1) begin
			n_errors++;
			$display("[ERR] %0t interrupt wait timed out", $time);
			give_verdict;
		end
	endtask : wait_irq

	task automatic give_verdict;
		$display("mismatches %0d comparisons %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : give_verdict

	// ======================================================================
	// Main sequence.
	// ======================================================================
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		tmr_run <= 1'b1;
		// Reset values, then an unmapped place that must ignore writes.
		expect_reg(RA, 8'h00);
		expect_reg(RB, 8'h00);
		expect_reg(RF, 8'h00);
		wr_reg(8'h55, 8'hff);
		expect_reg(8'h55, 8'h00);
		check({ch_a, rf_a, con_a, pw_a, irq, 1'b0}, 8'h00);
		// Condition codes 0 to 5 on comparator A; the last two rows must stay quiet.
		for (int i = 0; i < 7; i++) begin
			lvl(2, st[i] ? HI : LO);
			wr_reg(RA, {2'h2, 3'h5, cnd[i]});
			step(40);
			wr_reg(RA, {2'h2, 3'h5, cnd[i]});
			lvl(2, st[i] ? LO : HI);
			step(40);
			expect_reg(RA, {2'h2, 1'b1, ex[i], 1'b1, cnd[i]});
		end
		// A high-level event latches, survives the level going away, and drives the request.
		wr_reg(RA, 8'ha9);
		wait_irq;
		lvl(2, LO);
		step(20);
		expect_reg(RA, 8'hb9);
		check({7'h00, irq}, 8'h01);
		// Writing one to a set flag must not clear it; only a zero clears.
		wr_reg(RA, 8'hb9);
		step(3);
		check({7'h00, irq}, 8'h01);
		wr_reg(RA, 8'ha9);
		step(3);
		check({7'h00, irq}, 8'h00);
		expect_reg(RA, 8'ha9);
		// Disabled comparator: output low, no events.
		wr_reg(RA, 8'ha1);
		lvl(2, HI);
		step(30);
		expect_reg(RA, 8'ha1);
		check({7'h00, pw_a}, 8'h00);
		// Power-down overrides the enable bit.
		@(posedge clk);
		power_down <= 1'b1;
		wr_reg(RA, 8'ha9);
		step(30);
		expect_reg(RA, 8'ha9);
		check({7'h00, pw_a}, 8'h00);
		// Idle leaves the comparator running.
		@(posedge clk);
		power_down <= 1'b0;
		idle <= 1'b1;
		wait_irq;
		check({6'h00, pw_a, con_a}, 8'h03);
		expect_reg(RA, 8'hb9);
		idle <= 1'b0;
		// Timer-paced sampling: a short glitch is rejected, a held change is taken.
		for (int s = 1; s < 4; s++) begin
			lvl(2, LO);
			wr_reg(RF, {2'h0, 2'(s), 4'h0});
			step(60);
			wr_reg(RA, 8'had);
			lvl(2, HI);
			lvl(2, LO);
			step(60);
			expect_reg(RA, 8'had);
			lvl(2, HI);
			wait_irq;
			expect_reg(RA, 8'hbd);
		end
		// Clock sampling debounce: a glitch is discarded, a held edge waits for timer 1.
		lvl(2, LO);
		wr_reg(RF, 8'h00);
		step(40);
		wr_reg(RA, 8'had);
		lvl(2, HI);
		lvl(2, LO);
		step(40);
		expect_reg(RA, 8'had);
		tmr_run <= 1'b0;
		lvl(2, HI);
		step(40);
		expect_reg(RA, 8'had);
		tmr_run <= 1'b1;
		wait_irq;
		expect_reg(RA, 8'hbd);
		wr_reg(RA, 8'h00);
		// Comparator B: a level between the steps is below one reference, above another.
		lvl(3, 8'h83);
		wr_reg(RF, 8'h04);
		wr_reg(RB, 8'he9);
		step(40);
		expect_reg(RB, 8'he9);
		check({ch_b, rf_b, con_b, pw_b, irq, 1'b0}, 8'hdc);
		wr_reg(RB, 8'hc9);
		wr_reg(RF, 8'h08);
		#1;
		check({6'h00, rf_b}, 8'h02);
		wr_reg(RB, 8'he9);
		wait_irq;
		expect_reg(RB, 8'hf9);
		// With the clock enable low a write must be ignored.
		@(posedge clk);
		ce <= 1'b0;
		wr_reg(RB, 8'h00);
		ce <= 1'b1;
		expect_reg(RB, 8'hf9);
		expect_reg(RA, 8'h00);
		give_verdict;
	end
endmodule : dcel_top_bench
